//--- design/cdt_top.sv
// Contract
// - timer counts only while run enable set
// - select bits pick 32, 8, 1, 0.5 Hz
// - 16-bit count from two bytes, decrements per tick
// - zero count stops; period ends at zero
// - enabled timer sets flag at each expiry
// - auto reload restarts period with programmed count
// - reload takes one extra tick: n+1
// - interrupt pin follows flag until cleared
// - select and reload writable only while stopped
// - count writable only with run, reload clear
// - irq enable clear means flag never set
// - reset: stopped, no reload, 32 Hz, no enables
module cdt_top #(
    parameter int CLK_HZ = cdt_pkg::CLK_HZ,
    parameter int OSC_HZ = cdt_pkg::OSC_HZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic int_n_out,
    output logic int_n_oe
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic run_ff;                          // timer_run_enable
    logic reload_ff;                       // auto_reload_enable
    logic [1:0] sel_ff;                    // {source_sel_hi, source_sel_lo}
    logic [7:0] plain_ff;                  // control bits owned elsewhere
    logic [7:0] ien_ff;                    // interrupt_enable contents
    logic tf_ff;                           // timer_expired_flag
    logic [cdt_pkg::CNT_W-1:0] n_ff;       // programmed count
    logic [cdt_pkg::CNT_W-1:0] cnt_ff;     // live count
    logic [7:0] rdata_ff;                  // read data holding register
    logic src_tick;                        // selected source enable
    logic wr_ctrl;                         // write to main_control
    logic wr_ien;                          // write to interrupt_enable
    logic wr_flag;                         // write to interrupt_flags
    logic cnt_open;                        // count bytes may be written
    logic wr_lo;                           // accepted low byte write
    logic wr_hi;                           // accepted high byte write
    logic expire;                          // countdown reaches zero now
    logic reload_now;                      // reload tick consumed now
    logic tf_set;                          // flag set event
    logic tf_clr;                          // flag clear by software
    logic [7:0] ctrl_rd;                   // main_control read view
    logic [7:0] nxt_rdata;                 // next read data

    // address match, shared by every decode below
    function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
        return a == t;
    endfunction

    // ------------------------------------------------------------
    // source clock
    // ------------------------------------------------------------
    cdt_src_tick #(
        .CLK_HZ(CLK_HZ),
        .OSC_HZ(OSC_HZ)
    ) u_src (
        .clk(clk),
        .rst(rst),
        .sel(sel_ff),
        .src_tick(src_tick)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    assign wr_ctrl = reg_wr && hit(reg_addr, cdt_pkg::ADDR_CTRL);
    assign wr_ien = reg_wr && hit(reg_addr, cdt_pkg::ADDR_IEN);
    assign wr_flag = reg_wr && hit(reg_addr, cdt_pkg::ADDR_FLAG);
    assign cnt_open = !run_ff && !reload_ff;
    assign wr_lo = reg_wr && hit(reg_addr, cdt_pkg::ADDR_CNT_LO) && cnt_open;
    assign wr_hi = reg_wr && hit(reg_addr, cdt_pkg::ADDR_CNT_HI) && cnt_open;

    // control register: run and plain bits are always writable, reload and select lock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_ff <= cdt_pkg::CTRL_RESET[cdt_pkg::BIT_RUN];
            reload_ff <= cdt_pkg::CTRL_RESET[cdt_pkg::BIT_RELOAD];
            sel_ff <= cdt_pkg::SEL_32HZ;
            plain_ff <= cdt_pkg::CTRL_RESET & cdt_pkg::CTRL_PLAIN;
        end else if (wr_ctrl) begin
            run_ff <= reg_wdata[cdt_pkg::BIT_RUN];
            plain_ff <= reg_wdata & cdt_pkg::CTRL_PLAIN;
            // a running timer ignores rate and reload changes
            if (!run_ff) begin
                reload_ff <= reg_wdata[cdt_pkg::BIT_RELOAD];
                sel_ff <= {reg_wdata[cdt_pkg::BIT_SEL_HI], reg_wdata[cdt_pkg::BIT_SEL_LO]};
            end
        end
    end

    // interrupt enables, unimplemented bits dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ien_ff <= cdt_pkg::IEN_RESET;
        end else if (wr_ien) begin
            ien_ff <= reg_wdata & cdt_pkg::IEN_MASK;
        end
    end

    // ------------------------------------------------------------
    // countdown
    // ------------------------------------------------------------
    assign expire = run_ff && src_tick && (cnt_ff == cdt_pkg::CNT_ONE);
    // reload only from an expired count; a zero program stays stopped
    assign reload_now = run_ff && src_tick && (cnt_ff == cdt_pkg::CNT_ZERO)
        && reload_ff && (n_ff != cdt_pkg::CNT_ZERO);

    // programmed value, loaded byte by byte while stopped with reload clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            n_ff <= cdt_pkg::CNT_ZERO;
        end else if (wr_lo) begin
            n_ff[7:0] <= reg_wdata;
        end else if (wr_hi) begin
            n_ff[15:8] <= reg_wdata;
        end
    end

    // live counter; a byte write also arms it with the new value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= cdt_pkg::CNT_ZERO;
        end else if (wr_lo) begin
            cnt_ff <= {n_ff[15:8], reg_wdata};
        end else if (wr_hi) begin
            cnt_ff <= {reg_wdata, n_ff[7:0]};
        end else if (reload_now) begin
            cnt_ff <= n_ff;
        end else if (run_ff && src_tick && (cnt_ff != cdt_pkg::CNT_ZERO)) begin
            cnt_ff <= cnt_ff - cdt_pkg::CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // flag and interrupt pin
    // ------------------------------------------------------------
    assign tf_set = expire && ien_ff[cdt_pkg::BIT_TIE];
    assign tf_clr = wr_flag && !reg_wdata[cdt_pkg::BIT_TF];

    // an expiry in the clearing cycle wins, so no event is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tf_ff <= 1'b0;
        end else if (tf_set) begin
            tf_ff <= 1'b1;
        end else if (tf_clr) begin
            tf_ff <= 1'b0;
        end
    end

    // open drain: pull low while the flag stands
    assign int_n_out = 1'b0;
    assign int_n_oe = tf_ff;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // count bytes read back the live counter, not the program
    always_comb begin
        ctrl_rd = plain_ff;
        ctrl_rd[cdt_pkg::BIT_RUN] = run_ff;
        ctrl_rd[cdt_pkg::BIT_RELOAD] = reload_ff;
        ctrl_rd[cdt_pkg::BIT_SEL_LO] = sel_ff[0];
        ctrl_rd[cdt_pkg::BIT_SEL_HI] = sel_ff[1];
        nxt_rdata = cdt_pkg::RD_ZERO;
        if (hit(reg_addr, cdt_pkg::ADDR_CTRL)) begin
            nxt_rdata = ctrl_rd;
        end else if (hit(reg_addr, cdt_pkg::ADDR_IEN)) begin
            nxt_rdata = ien_ff;
        end else if (hit(reg_addr, cdt_pkg::ADDR_FLAG)) begin
            nxt_rdata[cdt_pkg::BIT_TF] = tf_ff;
        end else if (hit(reg_addr, cdt_pkg::ADDR_CNT_LO)) begin
            nxt_rdata = cnt_ff[7:0];
        end else if (hit(reg_addr, cdt_pkg::ADDR_CNT_HI)) begin
            nxt_rdata = cnt_ff[15:8];
        end
    end

    // data held until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= cdt_pkg::RD_ZERO;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_tick_idle;
        !run_ff && src_tick && !wr_lo && !wr_hi;
    endsequence

    sequence s_clear_only;
        tf_clr && !tf_set;
    endsequence

    stopped_hold_a: assert property (@(posedge clk) disable iff (rst)
        s_tick_idle |=> $stable(cnt_ff))
        else $error("counter moved while stopped");

    count_step_a: assert property (@(posedge clk) disable iff (rst)
        (run_ff && src_tick && cnt_ff > cdt_pkg::CNT_ONE)
        |=> cnt_ff == $past(cnt_ff) - cdt_pkg::CNT_ONE)
        else $error("counter did not step down by one");

    zero_stop_a: assert property (@(posedge clk) disable iff (rst)
        (cnt_ff == cdt_pkg::CNT_ZERO && !reload_now && !wr_lo && !wr_hi)
        |=> cnt_ff == cdt_pkg::CNT_ZERO)
        else $error("zero count did not stay stopped");

    flag_set_a: assert property (@(posedge clk) disable iff (rst)
        (expire && ien_ff[cdt_pkg::BIT_TIE]) |=> tf_ff && int_n_oe)
        else $error("expiry did not raise the flag");

    reload_value_a: assert property (@(posedge clk) disable iff (rst)
        reload_now |=> cnt_ff == $past(n_ff))
        else $error("reload did not restore programmed count");

    reload_gap_a: assert property (@(posedge clk) disable iff (rst)
        (expire && reload_ff && n_ff != cdt_pkg::CNT_ZERO)
        |=> cnt_ff == cdt_pkg::CNT_ZERO)
        else $error("reload skipped the extra source tick");

    pin_release_a: assert property (@(posedge clk) disable iff (rst)
        s_clear_only |=> !int_n_oe && !tf_ff)
        else $error("flag clear did not release the pin");

    pin_hold_a: assert property (@(posedge clk) disable iff (rst)
        (tf_ff && !tf_clr) |=> int_n_oe)
        else $error("interrupt pin dropped without a clear");

    ctrl_lock_a: assert property (@(posedge clk) disable iff (rst)
        (run_ff && wr_ctrl) |=> $stable(sel_ff) && $stable(reload_ff))
        else $error("locked control field changed while running");

    count_lock_a: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && (run_ff || reload_ff)) |=> $stable(n_ff))
        else $error("count written while running or reloading");

    irq_gate_a: assert property (@(posedge clk) disable iff (rst)
        (!ien_ff[cdt_pkg::BIT_TIE] && !tf_ff) |=> !tf_ff)
        else $error("flag set with timer interrupt disabled");

    reset_state_a: assert property (@(posedge clk)
        rst |=> !run_ff && !reload_ff && sel_ff == cdt_pkg::SEL_32HZ
            && ien_ff == cdt_pkg::IEN_RESET)
        else $error("reset state wrong");

endmodule

//--- design/cdt_pkg.sv
package cdt_pkg;

    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000; // system clock rate
    localparam int OSC_HZ = 32_768;      // timekeeping oscillator rate
    localparam int ACC_W = 27;           // accumulator width, holds CLK_HZ

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;   // main_control
    localparam logic [7:0] ADDR_IEN = 8'h01;    // interrupt_enable
    localparam logic [7:0] ADDR_FLAG = 8'h02;   // interrupt_flags
    localparam logic [7:0] ADDR_CNT_LO = 8'h18; // count_low_byte
    localparam logic [7:0] ADDR_CNT_HI = 8'h19; // count_high_byte

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_RUN = 1;     // timer_run_enable in main_control
    localparam int BIT_RELOAD = 2;  // auto_reload_enable in main_control
    localparam int BIT_SEL_LO = 5;  // source_sel_lo in main_control
    localparam int BIT_SEL_HI = 6;  // source_sel_hi in main_control
    localparam int BIT_TIE = 1;     // timer_irq_enable in interrupt_enable
    localparam int BIT_TF = 1;      // timer_expired_flag in interrupt_flags
    localparam logic [7:0] CTRL_RESET = 8'h99;  // main_control after reset
    localparam logic [7:0] CTRL_PLAIN = 8'h99;  // bits stored but unused here
    localparam logic [7:0] IEN_MASK = 8'h1F;    // implemented enable bits
    localparam logic [7:0] IEN_RESET = 8'h00;   // all enables off
    localparam logic [7:0] RD_ZERO = 8'h00;     // unmapped / empty read

    // ------------------------------------------------------------
    // source clock selection
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_32HZ = 2'h0;
    localparam logic [1:0] SEL_8HZ = 2'h1;
    localparam logic [1:0] SEL_1HZ = 2'h2;
    localparam logic [1:0] SEL_0P5HZ = 2'h3;
    localparam int PRE_W = 16;                        // prescaler width
    localparam logic [15:0] MASK_32HZ = 16'h03FF;     // 1024 oscillator ticks
    localparam logic [15:0] MASK_8HZ = 16'h0FFF;      // 4096 oscillator ticks
    localparam logic [15:0] MASK_1HZ = 16'h7FFF;      // 32768 oscillator ticks
    localparam logic [15:0] MASK_0P5HZ = 16'hFFFF;    // 65536 oscillator ticks

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // prescaler phase mask for a source selection
    function automatic logic [15:0] sel_mask(input logic [1:0] sel);
        logic [15:0] m;
        m = MASK_32HZ;
        unique case (sel)
            SEL_32HZ: m = MASK_32HZ;
            SEL_8HZ: m = MASK_8HZ;
            SEL_1HZ: m = MASK_1HZ;
            SEL_0P5HZ: m = MASK_0P5HZ;
        endcase
        return m;
    endfunction

endpackage

//--- design/cdt_src_tick.sv
module cdt_src_tick #(
    parameter int CLK_HZ = cdt_pkg::CLK_HZ,
    parameter int OSC_HZ = cdt_pkg::OSC_HZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] sel,
    output logic src_tick
);

    localparam int ACC_W1 = cdt_pkg::ACC_W + 1;

    // ------------------------------------------------------------
    // oscillator enable
    // ------------------------------------------------------------
    logic [cdt_pkg::ACC_W-1:0] acc_ff;             // fractional phase
    logic [ACC_W1-1:0] acc_sum;                    // phase plus step
    logic osc_hit;                                 // phase wrapped
    logic osc_tick_ff;                             // 32.768 kHz enable pulse
    logic [cdt_pkg::PRE_W-1:0] pre_ff;             // oscillator tick prescaler
    logic [cdt_pkg::PRE_W-1:0] mask;               // phase of the chosen rate
    logic src_tick_ff;                             // selected source enable

    assign acc_sum = {1'b0, acc_ff} + ACC_W1'(OSC_HZ);
    assign osc_hit = acc_sum >= ACC_W1'(CLK_HZ);
    assign mask = cdt_pkg::sel_mask(sel);
    assign src_tick = src_tick_ff;

    // rate ratio is not whole, so an accumulator keeps the average exact
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff <= '0;
            osc_tick_ff <= 1'b0;
        end else begin
            osc_tick_ff <= osc_hit;
            if (osc_hit) begin
                acc_ff <= cdt_pkg::ACC_W'(acc_sum - ACC_W1'(CLK_HZ));
            end else begin
                acc_ff <= acc_sum[cdt_pkg::ACC_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // prescaler and rate select
    // ------------------------------------------------------------
    // free running, so the first period may start mid-phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_ff <= '0;
            src_tick_ff <= 1'b0;
        end else begin
            src_tick_ff <= osc_tick_ff && ((pre_ff & mask) == mask);
            if (osc_tick_ff) begin
                pre_ff <= pre_ff + 16'h0001;
            end
        end
    end

    src_rate_a: assert property (@(posedge clk) disable iff (rst)
        src_tick_ff |-> (($past(pre_ff) & cdt_pkg::sel_mask($past(sel)))
            == cdt_pkg::sel_mask($past(sel))))
        else $error("source tick off its prescaler phase");

    tick_single_a: assert property (@(posedge clk) disable iff (rst)
        src_tick_ff |=> !src_tick_ff)
        else $error("source tick longer than one cycle");

endmodule

//--- tb/cdt_host.sv
// ------------------------------------------------------------
// host side of the register port
// ------------------------------------------------------------
module cdt_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // one write strobe, launched and dropped on falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = dat;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // released lines flip so a stale value never looks valid
        reg_addr = ~a;
        reg_wdata = ~dat;
    endtask

    // one read strobe; data is registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        dat = reg_rdata;
    endtask
endmodule

//--- tb/countdown_timer_irq_test.sv
module countdown_timer_irq_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // wiring
    // ------------------------------------------------------------
    localparam int OSC_DIV = 2;          // clk cycles per oscillator tick
    localparam int T32 = OSC_DIV * 1024; // clk cycles per 32 Hz tick
    localparam int T8 = OSC_DIV * 4096;  // clk cycles per 8 Hz tick
    logic clk;
    logic rst;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic int_n_out;
    logic int_n_oe;
    logic int_wire;      // pin level with its pull-up
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;         // free cycle count for interval timing
    int t1;
    int t2;
    logic [7:0] v1;

    assign int_wire = int_n_oe ? int_n_out : 1'b1;
    always @(posedge clk) cyc <= cyc + 1;

    // small clock ratio keeps the long source periods short
    cdt_top #(.CLK_HZ(2), .OSC_HZ(1)) u_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
    cdt_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared checks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // read a register and compare
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        u_host.rd(a, got);
        chk(what, exp, got);
    endtask

    // pin asserted: enable high and wire pulled low
    task automatic pin_chk(input logic on);
        chk("int_n_oe", {7'h00, on}, {7'h00, int_n_oe});
        chk("int wire", {7'h00, ~on}, {7'h00, int_wire});
    endtask

    // interval between expiries, two cycles of slack
    task automatic ichk(input string what, input int exp, input int got);
        cmp_count++;
        if (got < exp - 2 || got > exp + 2) begin
            failures++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // bounded wait for the interrupt; running out ends the run
    task automatic wait_int(input int bound, output int t);
        t = -1;
        for (int i = 0; i < bound && t < 0; i++) begin
            @(negedge clk);
            if (int_n_oe === 1'b1) t = cyc;
        end
        if (t < 0) begin
            failures++;
            $display("ERROR int_n_oe expected 1 seen %b", int_n_oe);
            give_verdict();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk("main_control", 8'h00, 8'h99);
        rchk("interrupt_enable", 8'h01, 8'h00);
        rchk("interrupt_flags", 8'h02, 8'h00);
        rchk("count_high_byte", 8'h19, 8'h00);
        rchk("unmapped", 8'h05, 8'h00);
        pin_chk(1'b0);
        $display("test reset done");
    endtask

    // every source code reads back as written while stopped
    task automatic t_sel();
        for (int s = 0; s < 4; s++) begin
            u_host.wr(8'h00, 8'h99 | 8'(s << 5));
            rchk("source select", 8'h00, 8'h99 | 8'(s << 5));
        end
        u_host.wr(8'h00, 8'h99);
        $display("test select done");
    endtask

    // a zero count never expires
    task automatic t_zero();
        u_host.wr(8'h01, 8'h02);
        u_host.wr(8'h00, 8'h9B);
        repeat (3 * T32) @(negedge clk);
        pin_chk(1'b0);
        rchk("flag at zero count", 8'h02, 8'h00);
        u_host.wr(8'h00, 8'h99);
        $display("test zero done");
    endtask

    // n=3 with reload at 32 Hz, refused writes, stop
    task automatic t_reload32();
        u_host.wr(8'h18, 8'h03);
        u_host.wr(8'h19, 8'h00);
        rchk("count low", 8'h18, 8'h03);
        u_host.wr(8'h00, 8'h9D);
        u_host.wr(8'h00, 8'h9F);
        u_host.wr(8'h00, 8'hFF);
        rchk("locked control", 8'h00, 8'h9F);
        wait_int(4 * T32 + 20, t1);
        repeat (100) @(negedge clk);
        pin_chk(1'b1);
        rchk("flag set", 8'h02, 8'h02);
        u_host.wr(8'h02, 8'h02);
        pin_chk(1'b1);
        u_host.wr(8'h02, 8'h00);
        pin_chk(1'b0);
        wait_int(4 * T32 + 20, t2);
        ichk("reload period", 4 * T32, t2 - t1);
        u_host.wr(8'h02, 8'h00);
        u_host.wr(8'h00, 8'h9D);
        u_host.rd(8'h18, v1);
        repeat (2 * T32) @(negedge clk);
        rchk("stopped count", 8'h18, v1);
        u_host.wr(8'h18, 8'h55);
        rchk("count locked by reload", 8'h18, v1);
        u_host.wr(8'h00, 8'h99);
        u_host.wr(8'h18, 8'h55);
        rchk("count open", 8'h18, 8'h55);
        $display("test reload32 done");
    endtask

    // n=1 with reload at 8 Hz
    task automatic t_reload8();
        u_host.wr(8'h00, 8'hB9);
        u_host.wr(8'h18, 8'h01);
        u_host.wr(8'h19, 8'h00);
        u_host.wr(8'h00, 8'hBD);
        u_host.wr(8'h00, 8'hBF);
        wait_int(2 * T8 + 20, t1);
        u_host.wr(8'h02, 8'h00);
        wait_int(2 * T8 + 20, t2);
        ichk("8 Hz period", 2 * T8, t2 - t1);
        u_host.wr(8'h02, 8'h00);
        u_host.wr(8'h00, 8'hBD);
        u_host.wr(8'h00, 8'h99);
        $display("test reload8 done");
    endtask

    // enable off: count reaches zero, no flag
    task automatic t_no_irq();
        u_host.wr(8'h01, 8'h00);
        u_host.wr(8'h18, 8'h01);
        u_host.wr(8'h19, 8'h00);
        u_host.wr(8'h00, 8'h9B);
        repeat (3 * T32) @(negedge clk);
        pin_chk(1'b0);
        rchk("flag masked", 8'h02, 8'h00);
        rchk("count at end", 8'h18, 8'h00);
        $display("test no_irq done");
    endtask

    // reset in mid-run with the flag standing must bring back the idle state
    task automatic t_rerst();
        u_host.wr(8'h00, 8'h99);
        u_host.wr(8'h01, 8'hFF);
        rchk("enable bits stored", 8'h01, 8'h1F);
        u_host.wr(8'h18, 8'h01);
        u_host.wr(8'h00, 8'h9B);
        wait_int(T32 + 20, t1);
        @(negedge clk);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        pin_chk(1'b0);
        rchk("main_control after reset", 8'h00, 8'h99);
        rchk("interrupt_enable after reset", 8'h01, 8'h00);
        rchk("interrupt_flags after reset", 8'h02, 8'h00);
        $display("test rerst done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_sel();
        t_zero();
        t_reload32();
        t_reload8();
        t_no_irq();
        t_rerst();
        give_verdict();
    end
endmodule
